/* File: rtl/lane_cell.sv */
// Lane cell: x8 serializer/deserializer, receive queue, delay taps and pad drive
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Receive word is eight bits, parallel-clock timed
// - Core supplies eight-bit transmit word on parallel clock
// - Receive reset clears queue and deserializer
// - Delay step enable moves delay up/down
// - Delay clear returns delay to initial tap
// - Queue empty flag registered every CLK_IN cycle
// - Core read enable pops one queue word
// - Clock lane gives core a parallel clock
// - Core uses that clock as queue read clock
// - Clock lane derives clocks from pads, group-only
// - Transmit clocks come from an external synthesizer
// - Low-power pad levels returned to core, registered on CLK_IN
// - Reversible receive lane accepts low-power drive
// - Each low-power pad driven only when enabled
// - Reversible transmit lane returns pad levels
// - Serial data driven only while enable asserted
// - Core switches receive buffer and termination
// - Factor-eight high-speed, low-power bypasses deserializer
module lane_cell
  import lane_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire lane_role_t LANE_ROLE_IN,
  input wire logic PAD_P_IN,
  input wire logic PAD_N_IN,
  output logic PAD_P_OUT,
  output logic PAD_P_OE_N_OUT,
  output logic PAD_N_OUT,
  output logic PAD_N_OE_N_OUT,
  output logic HS_TERMINATION_OUT,
  input wire logic GROUP_PARALLEL_CLK_IN,
  input wire logic GROUP_SERIAL_CLK_IN,
  output logic LANE_PARALLEL_CLK_OUT,
  output logic LANE_SERIAL_CLK_OUT,
  lane_if.lane bus
);

  // ***************************************************************
  // Role decode and clock enables
  // ***************************************************************
  logic pad_p_q;
  logic [DIV_W-1:0] div_q;
  wire is_tx = (LANE_ROLE_IN == ROLE_TX);
  wire is_clk_lane = (LANE_ROLE_IN == ROLE_RX_CLOCK);
  // Clock lane sees its serial clock as transitions on the P pad
  wire pad_edge = PAD_P_IN ^ pad_p_q;
  wire own_par_tick = pad_edge && (div_q == DIV_LAST);
  wire serial_en = is_tx ? bus.serial_clk :
                   (is_clk_lane ? pad_edge : GROUP_SERIAL_CLK_IN);
  wire parallel_en = is_tx ? bus.parallel_clk :
                     (is_clk_lane ? own_par_tick : GROUP_PARALLEL_CLK_IN);

  // Sampled through reset too, so a pad idling high gives no false edge
  always_ff @(posedge CLK_IN) begin
    pad_p_q <= PAD_P_IN;
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || !is_clk_lane) begin
      div_q <= 3'h0; // First tick on the eighth pad edge, never a part word
    end else if (pad_edge) begin
      div_q <= div_q + 3'h1;
    end
  end

  // Only clock lanes drive the group buses; data lanes keep them low
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      LANE_PARALLEL_CLK_OUT <= 1'b0;
      LANE_SERIAL_CLK_OUT <= 1'b0;
      bus.core_parallel_clk_out <= 1'b0;
    end else begin
      LANE_PARALLEL_CLK_OUT <= is_clk_lane && own_par_tick;
      LANE_SERIAL_CLK_OUT <= is_clk_lane && pad_edge;
      bus.core_parallel_clk_out <= is_clk_lane && own_par_tick;
    end
  end

  // ***************************************************************
  // Low-power levels back to the core
  // ***************************************************************
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      bus.lp_pos_rx_level <= 1'b0;
      bus.lp_neg_rx_level <= 1'b0;
    end else begin
      bus.lp_pos_rx_level <= PAD_P_IN;
      bus.lp_neg_rx_level <= PAD_N_IN;
    end
  end

  // ***************************************************************
  // Input delay taps
  // ***************************************************************
  logic [DELAY_W-1:0] delay_q;
  logic [SER_FACTOR-1:0] delay_line_q;
  wire delay_at_max = (delay_q == DELAY_MAX);
  wire delay_at_min = (delay_q == DELAY_MIN);
  wire delayed_bit = delay_line_q[delay_q];

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      delay_q <= DELAY_INIT;
    end else if (parallel_en && bus.delay_counter_clear) begin
      delay_q <= DELAY_INIT;
    end else if (parallel_en && bus.delay_step_en) begin
      // Saturate at the ends rather than wrap, so a sweep never jumps
      if (bus.delay_step_up && !delay_at_max) begin
        delay_q <= delay_q + 3'h1;
      end else if (!bus.delay_step_up && !delay_at_min) begin
        delay_q <= delay_q - 3'h1;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      delay_line_q <= WORD_ZERO;
    end else begin
      delay_line_q <= {delay_line_q[SER_FACTOR-2:0], PAD_P_IN};
    end
  end

  // ***************************************************************
  // Deserializer
  // ***************************************************************
  logic [WORD_W-1:0] rx_shift_q;
  wire hs_rx_active = !is_tx && bus.hs_rx_buffer_en;
  // First received bit ends up in bit 0
  wire [WORD_W-1:0] rx_shift_d = {delayed_bit, rx_shift_q[WORD_W-1:1]};

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || bus.rx_reset) begin
      rx_shift_q <= WORD_ZERO;
    end else if (hs_rx_active && serial_en) begin
      rx_shift_q <= rx_shift_d;
    end
  end

  // ***************************************************************
  // Receive queue
  // ***************************************************************
  logic [WORD_W-1:0] queue_mem [QUEUE_DEPTH];
  logic [QPTR_W-1:0] wr_ptr_q;
  logic [QPTR_W-1:0] rd_ptr_q;
  logic [QCNT_W-1:0] count_q;
  wire [WORD_W-1:0] push_word = serial_en ? rx_shift_d : rx_shift_q;
  // Words arriving while full are dropped; the queue never overwrites
  wire push = hs_rx_active && parallel_en && (count_q != QCNT_FULL);
  wire pop = bus.rx_queue_read_clk && bus.rx_queue_read_en && (count_q != QCNT_ZERO);
  wire [QCNT_W-1:0] count_d = count_q + (push ? QCNT_ONE : QCNT_ZERO)
                              - (pop ? QCNT_ONE : QCNT_ZERO);

  always_ff @(posedge CLK_IN) begin
    if (push) begin
      queue_mem[wr_ptr_q] <= push_word;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || bus.rx_reset) begin
      wr_ptr_q <= 2'h0;
      rd_ptr_q <= 2'h0;
      count_q <= QCNT_ZERO;
      bus.rx_queue_empty <= 1'b1;
      bus.hs_rx_word <= WORD_ZERO;
    end else begin
      count_q <= count_d;
      bus.rx_queue_empty <= (count_d == QCNT_ZERO);
      if (push) begin
        wr_ptr_q <= wr_ptr_q + QPTR_ONE;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + QPTR_ONE;
        bus.hs_rx_word <= queue_mem[rd_ptr_q];
      end
    end
  end

  // ***************************************************************
  // Serializer
  // ***************************************************************
  logic [WORD_W-1:0] tx_shift_q;

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || bus.tx_reset) begin
      tx_shift_q <= WORD_ZERO;
    end else if (is_tx && parallel_en) begin
      tx_shift_q <= bus.hs_tx_word;
    end else if (is_tx && serial_en) begin
      tx_shift_q <= {1'b0, tx_shift_q[WORD_W-1:1]};
    end
  end

  // ***************************************************************
  // Pad drive
  // ***************************************************************
  wire hs_drive = is_tx && bus.hs_drive_en;
  wire tx_bit = tx_shift_q[0];
  // Low-power drive also serves a reversible receive lane
  wire p_level_d = hs_drive ? tx_bit : bus.lp_pos_tx_level;
  wire n_level_d = hs_drive ? !tx_bit : bus.lp_neg_tx_level;
  wire p_oe_n_d = !(hs_drive || bus.lp_pos_drive_en);
  wire n_oe_n_d = !(hs_drive || bus.lp_neg_drive_en);

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PAD_P_OUT <= 1'b0;
      PAD_N_OUT <= 1'b0;
      PAD_P_OE_N_OUT <= 1'b1;
      PAD_N_OE_N_OUT <= 1'b1;
      HS_TERMINATION_OUT <= 1'b0;
    end else begin
      PAD_P_OUT <= p_level_d;
      PAD_N_OUT <= n_level_d;
      PAD_P_OE_N_OUT <= p_oe_n_d;
      PAD_N_OE_N_OUT <= n_oe_n_d;
      HS_TERMINATION_OUT <= !is_tx && bus.hs_rx_termination_en;
    end
  end

endmodule // lane_cell
`default_nettype wire

/* File: rtl/lane_core.sv */
// Core-side controller end: clock synthesis, transmit feed and receive queue draining
`timescale 1ns/1ps
`default_nettype none
module lane_core
  import lane_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic [WORD_W-1:0] HS_TX_WORD_IN,
  input wire logic HS_TX_ENABLE_IN,
  input wire logic LP_P_LEVEL_IN,
  input wire logic LP_N_LEVEL_IN,
  input wire logic LP_P_ENABLE_IN,
  input wire logic LP_N_ENABLE_IN,
  input wire logic RX_BUFFER_ENABLE_IN,
  input wire logic RX_TERM_ENABLE_IN,
  input wire logic DELAY_STEP_IN,
  input wire logic DELAY_UP_IN,
  input wire logic DELAY_CLEAR_IN,
  input wire logic RX_RESET_IN,
  input wire logic TX_RESET_IN,
  output logic TX_WORD_TAKEN_OUT,
  output logic [WORD_W-1:0] RX_WORD_OUT,
  output logic RX_WORD_VALID_OUT,
  output logic LP_P_SEEN_OUT,
  output logic LP_N_SEEN_OUT,
  lane_if.core bus
);

  // ***************************************************************
  // Clock synthesizer for transmit
  // ***************************************************************
  logic [DIV_W-1:0] div_q;
  wire par_tick = (div_q == DIV_LAST);
  logic read_pending_q;

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      div_q <= 3'h0;
      bus.serial_clk <= 1'b0;
      bus.parallel_clk <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      bus.serial_clk <= 1'b1;
      bus.parallel_clk <= par_tick;
    end
  end

  // ***************************************************************
  // Registered controls towards the lane
  // ***************************************************************
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      bus.hs_tx_word <= WORD_ZERO;
      bus.hs_drive_en <= 1'b0;
      bus.lp_pos_tx_level <= 1'b0;
      bus.lp_neg_tx_level <= 1'b0;
      bus.lp_pos_drive_en <= 1'b0;
      bus.lp_neg_drive_en <= 1'b0;
      bus.hs_rx_buffer_en <= 1'b0;
      bus.hs_rx_termination_en <= 1'b0;
      bus.delay_step_en <= 1'b0;
      bus.delay_step_up <= 1'b0;
      bus.delay_counter_clear <= 1'b0;
      bus.rx_reset <= 1'b0;
      bus.tx_reset <= 1'b0;
      TX_WORD_TAKEN_OUT <= 1'b0;
    end else begin
      // Word is held steady across the lane's parallel tick
      if (par_tick) begin
        bus.hs_tx_word <= HS_TX_WORD_IN;
      end
      TX_WORD_TAKEN_OUT <= par_tick;
      bus.hs_drive_en <= HS_TX_ENABLE_IN;
      bus.lp_pos_tx_level <= LP_P_LEVEL_IN;
      bus.lp_neg_tx_level <= LP_N_LEVEL_IN;
      bus.lp_pos_drive_en <= LP_P_ENABLE_IN;
      bus.lp_neg_drive_en <= LP_N_ENABLE_IN;
      bus.hs_rx_buffer_en <= RX_BUFFER_ENABLE_IN;
      bus.hs_rx_termination_en <= RX_TERM_ENABLE_IN;
      bus.delay_step_en <= DELAY_STEP_IN;
      bus.delay_step_up <= DELAY_UP_IN;
      bus.delay_counter_clear <= DELAY_CLEAR_IN;
      bus.rx_reset <= RX_RESET_IN;
      bus.tx_reset <= TX_RESET_IN;
    end
  end

  // ***************************************************************
  // Receive queue draining
  // ***************************************************************
  // Read clock is the clock lane's core clock, as a group would wire it
  wire read_clk_en = bus.core_parallel_clk_out;
  wire read_now = read_clk_en && !bus.rx_queue_empty;

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      bus.rx_queue_read_clk <= 1'b0;
      bus.rx_queue_read_en <= 1'b0;
      read_pending_q <= 1'b0;
      RX_WORD_OUT <= WORD_ZERO;
      RX_WORD_VALID_OUT <= 1'b0;
      LP_P_SEEN_OUT <= 1'b0;
      LP_N_SEEN_OUT <= 1'b0;
    end else begin
      bus.rx_queue_read_clk <= read_clk_en;
      bus.rx_queue_read_en <= read_now;
      read_pending_q <= bus.rx_queue_read_clk && bus.rx_queue_read_en && !bus.rx_queue_empty;
      RX_WORD_VALID_OUT <= read_pending_q;
      if (read_pending_q) begin
        RX_WORD_OUT <= bus.hs_rx_word;
      end
      LP_P_SEEN_OUT <= bus.lp_pos_rx_level;
      LP_N_SEEN_OUT <= bus.lp_neg_rx_level;
    end
  end

endmodule // lane_core
`default_nettype wire

/* File: rtl/lane_if.sv */
// Link between the lane cell and the core-side D-PHY controller
`timescale 1ns/1ps
`default_nettype none
interface lane_if;
  import lane_pkg::*;
  logic [WORD_W-1:0] hs_rx_word;
  logic [WORD_W-1:0] hs_tx_word;
  logic lp_pos_rx_level;
  logic lp_neg_rx_level;
  logic lp_pos_tx_level;
  logic lp_neg_tx_level;
  logic lp_pos_drive_en;
  logic lp_neg_drive_en;
  logic hs_drive_en;
  logic hs_rx_buffer_en;
  logic hs_rx_termination_en;
  logic rx_queue_empty;
  logic rx_queue_read_en;
  logic rx_queue_read_clk;
  logic rx_reset;
  logic tx_reset;
  logic delay_step_en;
  logic delay_step_up;
  logic delay_counter_clear;
  logic parallel_clk;
  logic serial_clk;
  logic core_parallel_clk_out;

  modport lane (
    output hs_rx_word, lp_pos_rx_level, lp_neg_rx_level, rx_queue_empty,
    output core_parallel_clk_out,
    input hs_tx_word, lp_pos_tx_level, lp_neg_tx_level, lp_pos_drive_en, lp_neg_drive_en,
    input hs_drive_en, hs_rx_buffer_en, hs_rx_termination_en, rx_queue_read_en,
    input rx_queue_read_clk, rx_reset, tx_reset, delay_step_en, delay_step_up,
    input delay_counter_clear, parallel_clk, serial_clk
  );

  modport core (
    input hs_rx_word, lp_pos_rx_level, lp_neg_rx_level, rx_queue_empty,
    input core_parallel_clk_out,
    output hs_tx_word, lp_pos_tx_level, lp_neg_tx_level, lp_pos_drive_en, lp_neg_drive_en,
    output hs_drive_en, hs_rx_buffer_en, hs_rx_termination_en, rx_queue_read_en,
    output rx_queue_read_clk, rx_reset, tx_reset, delay_step_en, delay_step_up,
    output delay_counter_clear, parallel_clk, serial_clk
  );
endinterface
`default_nettype wire

/* File: rtl/lane_pkg.sv */
// Shared constants and types for the high-speed lane cell and its core-side controller
package lane_pkg;
  // ***************************************************************
  // Widths and depths
  // ***************************************************************
  localparam int WORD_W = 8;
  localparam int SER_FACTOR = 8;
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = 3'h7;
  localparam int DELAY_W = 3;
  localparam logic [DELAY_W-1:0] DELAY_INIT = 3'h0;
  localparam logic [DELAY_W-1:0] DELAY_MAX = 3'h7;
  localparam logic [DELAY_W-1:0] DELAY_MIN = 3'h0;
  localparam int QUEUE_DEPTH = 4;
  localparam int QPTR_W = 2;
  localparam int QCNT_W = 3;
  localparam logic [QCNT_W-1:0] QCNT_FULL = 3'h4;
  localparam logic [QCNT_W-1:0] QCNT_ZERO = 3'h0;
  localparam logic [QCNT_W-1:0] QCNT_ONE = 3'h1;
  localparam logic [QPTR_W-1:0] QPTR_ONE = 2'h1;
  localparam logic [WORD_W-1:0] WORD_ZERO = 8'h00;

  // ***************************************************************
  // Lane roles
  // ***************************************************************
  typedef enum logic [1:0] {
    ROLE_RX_DATA,
    ROLE_RX_CLOCK,
    ROLE_TX
  } lane_role_t;
endpackage

/* File: tb/lane_link_asserts.sv */
// Concurrent checks on the signals of the lane link
`timescale 1ns/1ps
`default_nettype none
module lane_link_asserts
  import lane_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic [WORD_W-1:0] hs_rx_word,
  input wire logic rx_queue_empty,
  input wire logic rx_queue_read_en,
  input wire logic rx_queue_read_clk,
  input wire logic rx_reset,
  input wire logic hs_rx_buffer_en,
  input wire logic parallel_clk,
  input wire logic serial_clk,
  input wire logic core_parallel_clk_out
);
  wire logic pop;
  assign pop = rx_queue_read_clk && rx_queue_read_en && !rx_queue_empty;

  default clocking dc @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  // ***************************************************************
  // Clocking
  // ***************************************************************
  a_word_period: assert property (parallel_clk |=> (!parallel_clk) [*7] ##1 parallel_clk)
    else $error("parallel clock pulses are not eight cycles apart");
  a_serial_runs: assert property (!$past(RESET_IN) && !$past(RESET_IN, 2) |-> serial_clk)
    else $error("serial clock enable missing");
  a_core_clk_gap: assert property (core_parallel_clk_out |=> (!core_parallel_clk_out) [*7])
    else $error("core parallel clock pulses closer than eight");
  a_read_follows: assert property (rx_queue_read_clk |-> $past(core_parallel_clk_out))
    else $error("read clock not derived from lane clock");

  // ***************************************************************
  // Receive queue
  // ***************************************************************
  a_word_on_pop: assert property (!$stable(hs_rx_word) |-> $past(pop) || $past(rx_reset))
    else $error("receive word changed without a read");
  a_empty_cause: assert property ($rose(rx_queue_empty) |->
      $past(pop) || $past(pop, 2) || $past(rx_reset) || $past(rx_reset, 2))
    else $error("queue empty rose without read or reset");
  a_fill_needs_buf: assert property ($fell(rx_queue_empty) |->
      $past(hs_rx_buffer_en) || $past(hs_rx_buffer_en, 2))
    else $error("queue filled with input buffer off");
  a_reset_empties: assert property (rx_reset |-> ##[1:2] rx_queue_empty)
    else $error("receive reset left queue non-empty");
  a_reset_clears: assert property (rx_reset |-> ##[1:2] (hs_rx_word == WORD_ZERO))
    else $error("receive reset left receive word set");
endmodule // lane_link_asserts
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench joining the lane cell and the core end
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lane_pkg::*;
  logic CLK_IN, RESET_IN, pad_drv, toggle_on, p_out, p_oe_n, n_out, n_oe_n, term;
  logic tx_en, lp_p, lp_n, lp_p_en, lp_n_en, buf_en, term_en, dstep, dup, dclr, rx_rst;
  logic rx_valid, seen_p, seen_n, taken, lane_par, lane_ser, prev_step, prev_up, prev_clr;
  logic [DELAY_W-1:0] exp_dly;
  logic [7:0] tx_word, rx_word;
  logic [7:0] words [3];
  lane_role_t role;
  integer seed = 53602;
  int fail_count, num_checks, wd, got;
  wire logic p_pad;
  wire logic n_pad;
  // Pads resolve to the cell while it drives, else to the far side
  assign p_pad = !p_oe_n ? p_out : pad_drv;
  assign n_pad = !n_oe_n ? n_out : !pad_drv;

  lane_if bus ();
  lane_cell lane_cell_inst (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .LANE_ROLE_IN(role),
    .PAD_P_IN(p_pad), .PAD_N_IN(n_pad), .PAD_P_OUT(p_out), .PAD_P_OE_N_OUT(p_oe_n),
    .PAD_N_OUT(n_out), .PAD_N_OE_N_OUT(n_oe_n), .HS_TERMINATION_OUT(term),
    .GROUP_PARALLEL_CLK_IN(1'h0), .GROUP_SERIAL_CLK_IN(1'h0), .LANE_PARALLEL_CLK_OUT(lane_par),
    .LANE_SERIAL_CLK_OUT(lane_ser), .bus(bus));
  lane_core lane_core_inst (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .HS_TX_WORD_IN(tx_word),
    .HS_TX_ENABLE_IN(tx_en), .LP_P_LEVEL_IN(lp_p), .LP_N_LEVEL_IN(lp_n),
    .LP_P_ENABLE_IN(lp_p_en), .LP_N_ENABLE_IN(lp_n_en), .RX_BUFFER_ENABLE_IN(buf_en),
    .RX_TERM_ENABLE_IN(term_en), .DELAY_STEP_IN(dstep), .DELAY_UP_IN(dup),
    .DELAY_CLEAR_IN(dclr), .RX_RESET_IN(rx_rst), .TX_RESET_IN(1'h0), .TX_WORD_TAKEN_OUT(taken),
    .RX_WORD_OUT(rx_word), .RX_WORD_VALID_OUT(rx_valid), .LP_P_SEEN_OUT(seen_p),
    .LP_N_SEEN_OUT(seen_n), .bus(bus));
  lane_link_asserts lane_link_asserts_inst (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
    .hs_rx_word(bus.hs_rx_word), .rx_queue_empty(bus.rx_queue_empty),
    .rx_queue_read_en(bus.rx_queue_read_en), .rx_queue_read_clk(bus.rx_queue_read_clk),
    .rx_reset(bus.rx_reset), .hs_rx_buffer_en(bus.hs_rx_buffer_en),
    .parallel_clk(bus.parallel_clk), .serial_clk(bus.serial_clk),
    .core_parallel_clk_out(bus.core_parallel_clk_out));

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic lp_exp(input logic en, input logic lvl, input logic ext);
    return en ? lvl : ext;
  endfunction

  function automatic logic alt_ok(input logic [7:0] w);
    return (w === 8'h55) || (w === 8'hAA);
  endfunction

  // Clear wins over a step; steps stop at either end of the range
  function automatic logic [DELAY_W-1:0] next_delay(input logic [DELAY_W-1:0] d,
      input logic st, input logic up, input logic clr);
    if (clr) return DELAY_INIT;
    if (st && up && d != DELAY_MAX) return d + 3'h1;
    if (st && !up && d != DELAY_MIN) return d - 3'h1;
    return d;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge CLK_IN);
    #1;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic do_reset(input lane_role_t r);
    RESET_IN = 1'h1;
    role = r;
    step(3);
    RESET_IN = 1'h0;
  endtask

  // Far side held still at a random level while sampling, so random levels keep the pad honest
  task automatic lp_round;
    repeat (4) begin
      {lp_p, lp_n, lp_p_en, lp_n_en, pad_drv} = 5'($random(seed));
      step(6);
      check("p drive enable", 8'(p_oe_n), 8'(!lp_p_en));
      check("n drive enable", 8'(n_oe_n), 8'(!lp_n_en));
      check("p level seen", 8'(seen_p), 8'(lp_exp(lp_p_en, lp_p, pad_drv)));
      check("n level seen", 8'(seen_n), 8'(lp_exp(lp_n_en, lp_n, !pad_drv)));
    end
  endtask

  // ***************************************************************
  // Clock, stimulus and watchdog
  // ***************************************************************
  initial begin
    CLK_IN = 1'h0;
    forever #50 CLK_IN = ~CLK_IN;
  end

  always @(posedge CLK_IN) if (toggle_on) #1 pad_drv = ~pad_drv;

  initial begin
    #(100 * 5000);
    fail_count++;
    finish_test();
  end

  initial begin
    {pad_drv, toggle_on, tx_en, lp_p, lp_n, lp_p_en, lp_n_en} = 7'h00;
    {buf_en, term_en, dstep, dup, dclr, rx_rst} = 6'h00;
    tx_word = 8'h00;
    words = '{8'h01, 8'hB4, 8'h00};
    words[2] = 8'($random(seed));
    do_reset(ROLE_TX);
    tx_en = 1'h1;
    for (int k = 0; k < 3; k++) begin
      tx_word = words[k];
      step(24);
      wd = 0;
      while (bus.parallel_clk !== 1'h1 && wd < 16) begin
        step(1);
        wd++;
      end
      check("word taken", 8'(taken), 8'h01);
      step(2);
      for (int i = 0; i < 8; i++) begin
        check("tx bit p", 8'(p_out), 8'(words[k][i]));
        check("tx bit n", 8'(n_out), 8'(!words[k][i]));
        check("hs drive on", 8'(p_oe_n), 8'h00);
        step(1);
      end
    end
    tx_en = 1'h0;
    step(4);
    check("hs released", 8'(p_oe_n), 8'h01);
    lp_round();
    // Low-power drive off, or the lane would hold its own clock pad still
    {lp_p_en, lp_n_en} = 2'h0;
    do_reset(ROLE_RX_CLOCK);
    exp_dly = DELAY_INIT;
    {prev_step, prev_up, prev_clr} = 3'h0;
    buf_en = 1'h1;
    toggle_on = 1'h1;
    got = 0;
    for (int c = 0; c < 120; c++) begin
      {dstep, dup} = 2'($random(seed));
      // Held across a whole word so that one tick is sure to see it
      dclr = (c >= 60 && c < 68);
      step(1);
      if (rx_valid === 1'h1) begin
        got++;
        check("rx word pattern", 8'(alt_ok(rx_word)), 8'h01);
      end
      // Tap moves on the lane's own tick, with the controls of the cycle before
      if (bus.core_parallel_clk_out === 1'h1) begin
        exp_dly = next_delay(exp_dly, prev_step, prev_up, prev_clr);
        if (prev_clr) begin
          check("delay cleared", 8'(lane_cell_inst.delay_q), 8'(exp_dly));
        end else begin
          check("delay tap", 8'(lane_cell_inst.delay_q), 8'(exp_dly));
        end
        check("lane parallel clk", 8'(lane_par), 8'h01);
        check("lane serial clk", 8'(lane_ser), 8'h01);
      end
      {prev_step, prev_up, prev_clr} = {dstep, dup, dclr};
    end
    check("rx words arrived", 8'(got > 0), 8'h01);
    for (int t = 0; t < 2; t++) begin
      term_en = 1'(t);
      step(4);
      check("termination", 8'(term), 8'(t));
    end
    toggle_on = 1'h0;
    rx_rst = 1'h1;
    step(1);
    rx_rst = 1'h0;
    step(4);
    check("empty after rx reset", 8'(bus.rx_queue_empty), 8'h01);
    lp_round();
    finish_test();
  end
endmodule // tb
`default_nettype wire
